// *** hdl/sar_ctrl_pkg.sv ***
// sar_ctrl_pkg: constants and carrier types for the sar converter frame logic
// assumes core_clk at 100 MHz and a serial link clock sampled on it
package sar_ctrl_pkg;
	// ----------------------------------------------------------------
	// resolution and framing
	// ----------------------------------------------------------------
	localparam int RES_12_BITS      = 12;
	localparam int RES_10_BITS      = 10;
	localparam int DONE_EDGE_12     = 14;
	localparam int DONE_EDGE_10     = 11;
	localparam int DONE_EDGE_8      = 9;
	localparam int FRAME_WORD_BITS  = 16;
	localparam int LONG_FRAME_EDGE  = 30;
	localparam int CNT_W            = 6;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 100;
	localparam int WAKE_NS          = 1000;
	localparam int WAKE_CYCLES      = (WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int WAKE_W           = 8;

	function automatic int done_edge(input int res);
		return (res == RES_12_BITS) ? DONE_EDGE_12 :
			(res == RES_10_BITS) ? DONE_EDGE_10 : DONE_EDGE_8;
	endfunction

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic channel_select;
		logic power_down_request;
	} link_pins_t;

	typedef struct packed {
		logic sdo;
		logic sdo_oe;
	} sdo_pins_t;
endpackage

// *** hdl/pin_sync.sv ***
// pin_sync: two-flop synchroniser for a vector of pins
// assumes inputs are asynchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int           W       = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pins,
	output logic      [W-1:0] pins_sync
);
	logic [W-1:0] meta_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			// idle pin levels, so no false edge follows reset
			meta_q    <= RST_VAL;
			pins_sync <= RST_VAL;
		end else begin
			meta_q    <= pins;
			pins_sync <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** hdl/sar_frame_ctrl.sv ***
// sar_frame_ctrl: serial frame, conversion timing and auto power-down
// assumes a host spi master; analog core modelled by a sample code input per channel
//
// Summary of operation
// R1: channel_select low picks input pair 0, high picks pair 1.
// R2: host keeps channel_select stable until first rising edge after sampling.
// R3: host best sets channel between first and second rising edges.
// R4: conversion completes on rising edge 14, 11 or 9 by resolution.
// R5: result is unsigned straight binary of the resolution.
// R6: full scale is reference; one step is reference over two^res.
// R7: power-down request high at cs rise arms power-down next frame.
// R8: power-down request sampled only at cs rising edges.
// R9: power-down frame powers down after conversion, still shifts data out.
// R10: host best stops clock after 32nd falling edge in 32-clock.
// R11: wake begins on a rising edge and needs an extra interval.
// R12: host holds cs high over 1 us plus acquisition before first sample.
// R13: host raises power-down request before cs rise of last frame.
// R14: host may stop clock after 14th falling edge, best after 16th.
// R15: host gives at most 29 falling edges per frame for 16-clock.
// R16: device stays powered down while cs stays low.
// R17: cs rise with power-down request low restores normal operation.
// R18: serial clock serves as conversion clock.
// R19: host keeps serial clock fast and lowers frame rate instead.
// R20: host may use 32-clock framing with power-down below 500 kSPS.
// R21: cs fall samples input, drives msb, shifts on falling edges.
// R22: cs low through 30th falling edge selects 32-clock; next outputs zeros.
// R23: serial output is high impedance whenever cs is high.
`timescale 1ns/100ps
`default_nettype none
module sar_frame_ctrl
	import sar_ctrl_pkg::*;
#(
	parameter int RES = RES_12_BITS
) (
	input  wire logic           core_clk,
	input  wire logic           rst,
	input  wire link_pins_t     link_in,
	input  wire logic [RES-1:0] code_ch0,
	input  wire logic [RES-1:0] code_ch1,
	output sdo_pins_t           sdo_out,
	output logic                channel_sel_q,
	output logic                powered_down_q,
	output logic                fully_awake_q,
	output logic                long_frame_q,
	output logic [RES-1:0]      result_q
);
	localparam int DONE = done_edge(RES);
	localparam logic [CNT_W-1:0] DONE_CNT = CNT_W'(DONE);
	localparam logic [CNT_W-1:0] LONG_CNT = CNT_W'(LONG_FRAME_EDGE);
	localparam logic [CNT_W-1:0] WORD_CNT = CNT_W'(FRAME_WORD_BITS);
	localparam logic [WAKE_W-1:0] WAKE_CNT = WAKE_W'(WAKE_CYCLES);
	localparam link_pins_t PINS_IDLE = '{cs_n: 1'b1, default: 1'b0};

	// ----------------------------------------------------------------
	// pin synchronisation and edge finding
	// ----------------------------------------------------------------
	link_pins_t pins_s;
	link_pins_t pins_p_q;
	pin_sync #(.W($bits(link_pins_t)), .RST_VAL(PINS_IDLE)) u_sync (
		.core_clk  (core_clk),
		.rst       (rst),
		.pins      (link_in),
		.pins_sync (pins_s)
	);
	always_ff @(posedge core_clk) begin
		if (rst)
			pins_p_q <= PINS_IDLE;
		else
			pins_p_q <= pins_s;
	end
	logic cs_fall, cs_rise, sclk_rise, sclk_fall, cs_low;
	assign cs_low    = !pins_s.cs_n;
	assign cs_fall   = pins_p_q.cs_n && !pins_s.cs_n;
	assign cs_rise   = !pins_p_q.cs_n && pins_s.cs_n;
	assign sclk_rise = cs_low && !pins_p_q.sclk && pins_s.sclk;
	assign sclk_fall = cs_low && pins_p_q.sclk && !pins_s.sclk;

	// ----------------------------------------------------------------
	// frame edge counters
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] rise_cnt_q, fall_cnt_q;
	always_ff @(posedge core_clk) begin
		if (rst || cs_fall) begin
			rise_cnt_q <= '0;
			fall_cnt_q <= '0;
		end else begin
			if (sclk_rise && rise_cnt_q != '1)
				rise_cnt_q <= rise_cnt_q + 1'b1; // [R18]
			if (sclk_fall && fall_cnt_q != '1)
				fall_cnt_q <= fall_cnt_q + 1'b1;
		end
	end
	logic conv_done;
	assign conv_done = sclk_rise && (rise_cnt_q == DONE_CNT - 1'b1); // [R4]

	// ----------------------------------------------------------------
	// channel mux, sample and conversion
	// ----------------------------------------------------------------
	logic [RES-1:0] sample_q;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			channel_sel_q <= 1'b0;
			sample_q      <= '0;
			result_q      <= '0;
		end else begin
			channel_sel_q <= pins_s.channel_select; // [R1]
			if (cs_fall)
				sample_q <= channel_sel_q ? code_ch1 : code_ch0; // [R1]
			if (conv_done)
				result_q <= sample_q; // straight binary [R5] [R6]
		end
	end

	// ----------------------------------------------------------------
	// output shifter
	// ----------------------------------------------------------------
	logic [FRAME_WORD_BITS-1:0] shift_q;
	logic [FRAME_WORD_BITS-1:0] word_now;
	logic                       zeros_next_q;
	assign word_now = {result_q, {(FRAME_WORD_BITS-RES){1'b0}}};
	always_ff @(posedge core_clk) begin
		if (rst) begin
			shift_q <= '0;
			sdo_out <= '0;
		end else if (cs_fall) begin
			// long_frame_q still marks the frame that just ended
			shift_q <= long_frame_q ? '0 : word_now; // [R21] [R22]
			sdo_out <= '{sdo: long_frame_q ? 1'b0 : word_now[FRAME_WORD_BITS-1],
				sdo_oe: 1'b1}; // [R21]
		end else if (!cs_low) begin
			sdo_out <= '0; // [R23]
		end else if (sclk_fall) begin
			if (fall_cnt_q == WORD_CNT - 1'b1) begin
				// fresh result follows from the 16th falling edge
				shift_q     <= word_now;
				sdo_out.sdo <= word_now[FRAME_WORD_BITS-1];
			end else begin
				shift_q     <= {shift_q[FRAME_WORD_BITS-2:0], 1'b0};
				sdo_out.sdo <= shift_q[FRAME_WORD_BITS-2]; // [R9] [R21]
			end
		end
	end

	// ----------------------------------------------------------------
	// framing mode
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			long_frame_q <= 1'b0;
			zeros_next_q <= 1'b0;
		end else if (cs_fall) begin
			zeros_next_q <= long_frame_q; // [R22]
			long_frame_q <= 1'b0;
		end else if (sclk_fall && fall_cnt_q == LONG_CNT - 1'b1) begin
			long_frame_q <= 1'b1; // [R22]
		end
	end

	// ----------------------------------------------------------------
	// power-down
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PWR_ON, PWR_DOWN, PWR_WAKE} pwr_state_t;
	pwr_state_t       pwr_q;
	logic             pd_armed_q;
	logic [WAKE_W-1:0] wake_q;
	always_ff @(posedge core_clk) begin
		if (rst)
			pd_armed_q <= 1'b0;
		else if (cs_rise)
			pd_armed_q <= pins_s.power_down_request; // [R7] [R8]
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pwr_q          <= PWR_ON;
			wake_q         <= '0;
			powered_down_q <= 1'b0;
			fully_awake_q  <= 1'b1;
		end else begin
			unique case (pwr_q)
				PWR_ON: begin
					if (conv_done && pd_armed_q) begin
						pwr_q          <= PWR_DOWN; // [R9]
						powered_down_q <= 1'b1;
						fully_awake_q  <= 1'b0;
					end
				end
				PWR_DOWN: begin
					// held while cs low; a cs rise without request clears it
					if (cs_rise && !pins_s.power_down_request) begin
						pwr_q          <= PWR_WAKE; // [R17]
						powered_down_q <= 1'b0;
						wake_q         <= WAKE_CNT;
					end else if (!cs_low && sclk_rise_any()) begin
						pwr_q          <= PWR_WAKE; // [R11]
						powered_down_q <= 1'b0;
						wake_q         <= WAKE_CNT;
					end // [R16]
				end
				PWR_WAKE: begin
					if (wake_q == '0) begin
						pwr_q         <= PWR_ON; // [R11]
						fully_awake_q <= 1'b1;
					end else begin
						wake_q <= wake_q - 1'b1;
					end
				end
			endcase
		end
	end
	function automatic logic sclk_rise_any();
		return !pins_p_q.sclk && pins_s.sclk;
	endfunction

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_cs_up;
		!cs_low;
	endsequence
	property p_hiz_when_cs_high;
		@(posedge core_clk) disable iff (rst)
		s_cs_up ##1 !cs_fall |-> !sdo_out.sdo_oe;
	endproperty
	a_hiz_when_cs_high: assert property (p_hiz_when_cs_high) // [R23]
		else $error("sdo driven while cs high");
	property p_msb_on_fall;
		@(posedge core_clk) disable iff (rst)
		cs_fall && !long_frame_q |=> sdo_out.sdo_oe &&
			sdo_out.sdo == $past(result_q[RES-1]);
	endproperty
	a_msb_on_fall: assert property (p_msb_on_fall) // [R21]
		else $error("msb not driven at cs fall");
	property p_conv_edge;
		@(posedge core_clk) disable iff (rst)
		conv_done |=> result_q == $past(sample_q) &&
			rise_cnt_q == DONE_CNT;
	endproperty
	a_conv_edge: assert property (p_conv_edge) // [R4]
		else $error("conversion not on its edge");
	property p_pd_entry;
		@(posedge core_clk) disable iff (rst)
		pwr_q == PWR_ON && conv_done && pd_armed_q |=> powered_down_q;
	endproperty
	a_pd_entry: assert property (p_pd_entry) // [R9]
		else $error("no power-down after conversion");
	property p_pd_hold;
		@(posedge core_clk) disable iff (rst)
		powered_down_q && cs_low |=> powered_down_q;
	endproperty
	a_pd_hold: assert property (p_pd_hold) // [R16]
		else $error("woke while cs low");
	property p_pd_sample;
		@(posedge core_clk) disable iff (rst)
		!cs_rise |=> $stable(pd_armed_q);
	endproperty
	a_pd_sample: assert property (p_pd_sample) // [R8]
		else $error("request sampled off cs rise");
	property p_pd_exit;
		@(posedge core_clk) disable iff (rst)
		powered_down_q && cs_rise && !pins_s.power_down_request
			|=> !powered_down_q ##[1:110] fully_awake_q;
	endproperty
	a_pd_exit: assert property (p_pd_exit) // [R17] [R11]
		else $error("no exit from power-down");
	property p_long_zero;
		@(posedge core_clk) disable iff (rst)
		long_frame_q && cs_fall |=> sdo_out.sdo == 1'b0;
	endproperty
	a_long_zero: assert property (p_long_zero) // [R22]
		else $error("long frame did not send zeros");
	property p_zero_word;
		@(posedge core_clk) disable iff (rst)
		zeros_next_q && cs_low && fall_cnt_q < WORD_CNT |-> !sdo_out.sdo;
	endproperty
	a_zero_word: assert property (p_zero_word) // [R22]
		else $error("zero word broken before 16th fall");
	property p_sclk_wake;
		@(posedge core_clk) disable iff (rst)
		pwr_q == PWR_DOWN && !cs_low && !pins_p_q.sclk && pins_s.sclk
			|=> !powered_down_q;
	endproperty
	a_sclk_wake: assert property (p_sclk_wake) // [R11]
		else $error("clock edge did not start wake");
endmodule
`default_nettype wire

// *** bench/host_model.sv ***
// host_model: spi master model driving the frame pins
// assumes core_clk 100 MHz; sclk period 8 cycles (80 ns)
`timescale 1ns/100ps
`default_nettype none
module host_model
	import sar_ctrl_pkg::*;
(
	input  wire logic      core_clk,
	input  wire sdo_pins_t sdo_in,
	output var link_pins_t link_out
);
	int rises = 0;
	initial link_out = 4'h8;

	task automatic half(input logic lvl);
		link_out.sclk <= lvl;
		repeat (4) @(posedge core_clk);
	endtask

	// ----------------------------------------------------------------
	// one frame of n clocks; ch takes effect at the next sample
	// ----------------------------------------------------------------
	task automatic frame(input int n, input logic ch, input logic pdr,
		output logic [15:0] word);
		word = 16'h0000;
		rises = 0;
		repeat (120) @(posedge core_clk);
		link_out.cs_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		for (int i = 1; i <= n; i++) begin
			rises = i;
			if (i <= 16)
				// an undriven line reads as the inverse
				word = {word[14:0],
					sdo_in.sdo_oe ? sdo_in.sdo : ~sdo_in.sdo};
			half(1'b1);
			if (i == 1)
				link_out.channel_select <= ch;
			if (i == 5)
				link_out.power_down_request <= 1'b1;
			if (i == 10)
				link_out.power_down_request <= pdr;
			half(1'b0);
		end
		// clock stands still from here on
		repeat (8) @(posedge core_clk);
		link_out.cs_n <= 1'b1;
		// cs rise reaches the output three cycles later
		repeat (4) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// tb_top: self-checking bench for sar_frame_ctrl
// assumes the host model as the only driver of the link pins
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import sar_ctrl_pkg::*;
;
	logic       core_clk = 1'b0;
	logic       rst      = 1'b1;
	link_pins_t link;
	logic [11:0] code_ch0 = 12'hA5C;
	logic [11:0] code_ch1 = 12'h3F1;
	sdo_pins_t  sdo_out;
	logic       channel_sel_q;
	logic       powered_down_q;
	logic       fully_awake_q;
	logic       long_frame_q;
	logic [11:0] result_q;
	logic [15:0] w;
	int         checks = 0;
	int         bad_count = 0;

	always #5 core_clk = ~core_clk;

	sar_frame_ctrl #(.RES(RES_12_BITS)) i_dut (.core_clk(core_clk), .rst(rst),
		.link_in(link), .code_ch0(code_ch0), .code_ch1(code_ch1),
		.sdo_out(sdo_out), .channel_sel_q(channel_sel_q),
		.powered_down_q(powered_down_q), .fully_awake_q(fully_awake_q),
		.long_frame_q(long_frame_q), .result_q(result_q));
	host_model i_host (.core_clk(core_clk), .sdo_in(sdo_out),
		.link_out(link));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_res(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic upto(input int n);
		wait (i_host.rises == n);
		@(negedge core_clk);
	endtask

	task automatic summarize;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// plain 16-clock frame with result timing checks
	// ----------------------------------------------------------------
	task automatic conv(input logic ch, input logic pdr,
		input logic [11:0] old_r, input logic [11:0] new_r);
		fork
			i_host.frame(16, ch, pdr, w);
			begin
				upto(14);
				chk_res(result_q, old_r);
				chk_bit(sdo_out.sdo_oe, 1'b1);
				upto(15);
				chk_res(result_q, new_r);
				chk_bit(powered_down_q, 1'b0);
			end
		join
		@(negedge core_clk);
		chk({14'h0000, sdo_out}, 16'h0000);
	endtask

	initial begin
		// long frames and power-down walks stay well inside this
		repeat (20000) @(posedge core_clk);
		bad_count++;
		summarize();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		chk({14'h0000, sdo_out}, 16'h0000);
		chk({13'h0000, powered_down_q, fully_awake_q, long_frame_q},
			16'h0002);
		// no false frame from the synchroniser after reset
		repeat (4) @(negedge core_clk);
		chk({14'h0000, sdo_out}, 16'h0000);
		$display("test reset done");
	endtask

	task automatic test_channels();
		conv(1'b1, 1'b0, 12'h000, code_ch0);
		conv(1'b0, 1'b0, code_ch0, code_ch1);
		chk(w, {code_ch0, 4'h0});
		conv(1'b0, 1'b1, code_ch1, code_ch0);
		chk(w, {code_ch1, 4'h0});
		$display("test channels done");
	endtask

	task automatic test_clock_wake();
		// request still high at cs rise keeps the device down
		fork
			i_host.frame(16, 1'b0, 1'b1, w);
			begin
				upto(15);
				chk_bit(powered_down_q, 1'b1);
			end
		join
		@(negedge core_clk);
		chk_bit(powered_down_q, 1'b1);
		chk(w, {code_ch0, 4'h0});
		@(posedge core_clk);
		i_host.half(1'b1);
		i_host.half(1'b0);
		@(negedge core_clk);
		chk_bit(powered_down_q, 1'b0);
		chk_bit(fully_awake_q, 1'b0);
		repeat (120) @(negedge core_clk);
		chk_bit(fully_awake_q, 1'b1);
		$display("test clock wake done");
	endtask

	task automatic test_power_down();
		fork
			i_host.frame(16, 1'b0, 1'b0, w);
			begin
				upto(14);
				chk_bit(powered_down_q, 1'b0);
				upto(15);
				chk_bit(powered_down_q, 1'b1);
				upto(16);
				repeat (8) @(negedge core_clk);
				chk_bit(powered_down_q, 1'b1);
			end
		join
		chk(w, {code_ch0, 4'h0});
		repeat (8) @(negedge core_clk);
		chk_bit(powered_down_q, 1'b0);
		chk_bit(fully_awake_q, 1'b0);
		repeat (120) @(negedge core_clk);
		chk_bit(fully_awake_q, 1'b1);
		$display("test power down done");
	endtask

	task automatic test_long_frame();
		fork
			i_host.frame(30, 1'b0, 1'b0, w);
			begin
				upto(30);
				repeat (9) @(negedge core_clk);
				chk_bit(long_frame_q, 1'b1);
			end
		join
		chk(w, {code_ch0, 4'h0});
		conv(1'b0, 1'b0, code_ch0, code_ch0);
		chk(w, 16'h0000);
		$display("test long frame done");
	endtask

	initial begin
		test_reset();
		test_channels();
		test_clock_wake();
		test_power_down();
		test_long_frame();
		summarize();
	end
endmodule
`default_nettype wire
